//--- rtl/can_buf_consts.vh
`ifndef CAN_BUF_CONSTS_VH
`define CAN_BUF_CONSTS_VH
// Register offsets.
`define OFS_OPTION2 8'h00
`define OFS_MODE 8'h01
`define OFS_RX_FLAG 8'h02
`define OFS_RX_IE 8'h03
`define OFS_TX_FLAG 8'h04
`define OFS_TX_CTRL 8'h05
`define OFS_RX_WIN 8'h40
`define OFS_TX_WIN 8'h50
// Field positions.
`define BIT_CTRL_EN 0
`define BIT_LOOPBACK 0
`define BIT_RXF 0
`define BIT_OVR 1
`define BIT_RXFIE 0
`define BIT_OVRIE 1
`define TXE_LSB 0
`define ACK_LSB 4
`define CREQ_LSB 0
`define TXIE_LSB 4
// Buffer geometry.
`define BUF_BYTES 13
`define RANK_IDX 4'hD
`define NUM_TX 3
// Reset values.
`define RST_TXE 3'h7
`define RST_RANK 8'h00
`endif

//--- rtl/can_message_buffering.v
`timescale 1ns/1ps
`include "can_buf_consts.vh"
module can_message_buffering #(
   parameter RANK_W = 8
) (
   input wire ref_clk,
   input wire rst_b,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata_ff,
   input wire can_rx,
   output reg can_tx_ff,
   output reg can_rx_sync_ff,
   input wire pe_tx_bit,
   input wire pe_rx_wr,
   input wire [3:0] pe_rx_idx,
   input wire [7:0] pe_rx_byte,
   input wire pe_rx_ok,
   input wire pe_rx_hit,
   input wire pe_arb_start,
   input wire pe_arb_lost,
   input wire pe_tx_done,
   input wire pe_tx_err,
   input wire [3:0] pe_tx_idx,
   output reg [7:0] tx_byte_ff,
   output reg tx_req_ff,
   output reg [1:0] tx_sel_ff,
   output reg ack_en_ff,
   output reg module_en_ff,
   output reg rx_irq_ff,
   output reg err_irq_ff,
   output reg tx_irq_ff
);

   // Decodes a bus address into the transmit window: valid, buffer, byte.
   function [6:0] tx_slot;
      input [7:0] a;
      reg [1:0] n;
      begin
         n = a[5:4] - 2'd1;
         tx_slot = {(a[7:6] == 2'b01) && (a[5:4] != 2'b00) &&
                    (a[3:0] <= `RANK_IDX), n, a[3:0]};
      end
   endfunction

   // Message memories and the rank register of each transmit buffer.
   reg [7:0] rx_bg [0:`BUF_BYTES-1];
   reg [7:0] rx_fg [0:`BUF_BYTES-1];
   reg [7:0] tx_mem [0:3*`BUF_BYTES-1];
   reg [RANK_W-1:0] rank_ff [0:`NUM_TX-1];
   // Control bits, receive flags and per-buffer transmit state.
   reg en_ff;
   reg loopback_ff;
   reg rxf_ff;
   reg bg_held_ff;
   reg ovr_ff;
   reg rxfie_ff;
   reg ovrie_ff;
   reg own_ff;
   reg [2:0] txe_ff;
   reg [2:0] ack_ff;
   reg [2:0] creq_ff;
   reg [2:0] busy_ff;
   reg [2:0] txie_ff;
   reg rx_meta_ff;
   reg rx_sync_ff;
   // Next values and the selection found by combinational logic.
   reg nxt_rxf;
   reg nxt_bg_held;
   reg nxt_ovr;
   reg do_copy;
   reg [1:0] pick;
   reg pick_ok;
   reg [RANK_W-1:0] best;
   // Loop counters, one per process so that no two processes share one.
   integer i;
   integer j;
   integer k;
   // Address decode, memory indices and qualified strobes.
   wire [6:0] wslot;
   wire [6:0] rslot;
   wire [5:0] wmem_idx;
   wire [5:0] rmem_idx;
   wire [5:0] tmem_idx;
   wire rx_clr;
   wire accepted;
   wire tx_flag_wr;
   // Rank read value padded to the bus width before it is cut.
   wire [RANK_W+7:0] rank_wide;

   // The same decode serves the write and the read side of the bus.
   assign wslot = tx_slot(reg_addr);
   assign rslot = tx_slot(reg_addr);
   // Buffer n starts at byte 13n, built as 16n minus 2n minus n.
   assign wmem_idx = {wslot[5:4], 4'h0} - {3'b000, wslot[5:4], 1'b0} -
                     {4'h0, wslot[5:4]} + {2'b00, wslot[3:0]};
   assign rmem_idx = wmem_idx;
   assign tmem_idx = {tx_sel_ff, 4'h0} - {3'b000, tx_sel_ff, 1'b0} -
                     {4'h0, tx_sel_ff} + {2'b00, pe_tx_idx};
   assign rank_wide = {8'h00, rank_ff[rslot[5:4]]};
   // Write-one-to-clear strobe for the receive full flag.
   assign rx_clr = reg_wr && (reg_addr == `OFS_RX_FLAG) &&
                   reg_wdata[`BIT_RXF];
   // Only accepted frames that are not our own, unless looped back.
   assign accepted = en_ff && pe_rx_ok && pe_rx_hit &&
                     (!own_ff || loopback_ff);
   // Any write to the transmit flag register.
   assign tx_flag_wr = reg_wr && (reg_addr == `OFS_TX_FLAG);

   // Two flip-flops bring the receive pin into the clock domain.
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_meta_ff <= 1'b1;
         rx_sync_ff <= 1'b1;
      end else begin
         rx_meta_ff <= can_rx;
         rx_sync_ff <= rx_meta_ff;
      end
   end

   // Configuration registers written by software.
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         en_ff <= 1'b0;
         loopback_ff <= 1'b0;
         rxfie_ff <= 1'b0;
         ovrie_ff <= 1'b0;
         txie_ff <= 3'h0;
      end else if (reg_wr) begin
         case (reg_addr)
            `OFS_OPTION2: en_ff <= reg_wdata[`BIT_CTRL_EN];
            `OFS_MODE: loopback_ff <= reg_wdata[`BIT_LOOPBACK];
            `OFS_RX_IE: begin
               rxfie_ff <= reg_wdata[`BIT_RXFIE];
               ovrie_ff <= reg_wdata[`BIT_OVRIE];
            end
            `OFS_TX_CTRL: txie_ff <= reg_wdata[`TXIE_LSB+2:`TXIE_LSB];
            default: en_ff <= en_ff;
         endcase
      end
   end

   // Receive flag, held background and overrun; a set beats a clear.
   always @* begin
      nxt_rxf = rxf_ff;
      nxt_bg_held = bg_held_ff;
      nxt_ovr = ovr_ff;
      do_copy = 1'b0;
      if (accepted) begin
         if (!rxf_ff || (rx_clr && !bg_held_ff)) begin
            do_copy = 1'b1;
            nxt_rxf = 1'b1;
         end else if (!bg_held_ff) begin
            nxt_bg_held = 1'b1;
         end else begin
            nxt_ovr = 1'b1;
         end
      end else if (rx_clr) begin
         if (bg_held_ff) begin
            do_copy = 1'b1;
            nxt_bg_held = 1'b0;
         end else begin
            nxt_rxf = 1'b0;
         end
      end
      if (reg_wr && (reg_addr == `OFS_RX_FLAG) && reg_wdata[`BIT_OVR] &&
          !(accepted && rxf_ff && bg_held_ff)) begin
         nxt_ovr = 1'b0;
      end
   end

   // Receive state registers.
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rxf_ff <= 1'b0;
         bg_held_ff <= 1'b0;
         ovr_ff <= 1'b0;
      end else begin
         rxf_ff <= nxt_rxf;
         bg_held_ff <= nxt_bg_held;
         ovr_ff <= nxt_ovr;
      end
   end

   // Message memories; the engine fills the background buffer.
   always @(posedge ref_clk) begin
      if (en_ff && pe_rx_wr && !bg_held_ff &&
          (pe_rx_idx < `BUF_BYTES)) begin
         rx_bg[pe_rx_idx] <= pe_rx_byte;
      end
      if (do_copy) begin
         for (i = 0; i < `BUF_BYTES; i = i + 1) begin
            rx_fg[i] <= rx_bg[i];
         end
      end
      if (reg_wr && wslot[6] && (wslot[3:0] != `RANK_IDX)) begin
         tx_mem[wmem_idx] <= reg_wdata;
      end
   end

   // Rank registers, one per transmit buffer.
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (j = 0; j < `NUM_TX; j = j + 1) begin
            rank_ff[j] <= `RST_RANK;
         end
      end else if (reg_wr && wslot[6] && (wslot[3:0] == `RANK_IDX)) begin
         rank_ff[wslot[5:4]] <= reg_wdata[RANK_W-1:0];
      end
   end

   // Lowest rank among ready, non-cancelled buffers wins.
   always @* begin
      pick = 2'd0;
      pick_ok = 1'b0;
      best = {RANK_W{1'b1}};
      for (k = 0; k < `NUM_TX; k = k + 1) begin
         if (!txe_ff[k] && !creq_ff[k] &&
             (!pick_ok || (rank_ff[k] < best))) begin
            pick = k[1:0];
            pick_ok = 1'b1;
            best = rank_ff[k];
         end
      end
   end

   // Scheduler: choose at each arbitration, drop the request afterwards.
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_req_ff <= 1'b0;
         tx_sel_ff <= 2'd0;
         own_ff <= 1'b0;
      end else if (!en_ff) begin
         tx_req_ff <= 1'b0;
         own_ff <= 1'b0;
      end else if (pe_arb_start) begin
         tx_req_ff <= pick_ok;
         tx_sel_ff <= pick;
         own_ff <= pick_ok;
      end else if (pe_arb_lost) begin
         tx_req_ff <= 1'b0;
         own_ff <= 1'b0;
      end else if (pe_tx_done || pe_tx_err) begin
         tx_req_ff <= 1'b0;
      end else if (pe_rx_ok) begin
         own_ff <= 1'b0;
      end
   end

   // Per-buffer empty, cancel request, cancel ack and busy state.
   genvar g;
   generate
      for (g = 0; g < `NUM_TX; g = g + 1) begin : g_txbuf
         wire sent;
         wire grant;
         assign sent = en_ff && pe_tx_done && busy_ff[g] &&
                       (tx_sel_ff == g);
         // A buffer on the bus is never cancelled; its request waits.
         assign grant = creq_ff[g] && !txe_ff[g] && !busy_ff[g];
         always @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               txe_ff[g] <= 1'b1;
               ack_ff[g] <= 1'b0;
               creq_ff[g] <= 1'b0;
               busy_ff[g] <= 1'b0;
            end else begin
               if (sent) begin
                  txe_ff[g] <= 1'b1;
                  ack_ff[g] <= 1'b0;
               end else if (grant) begin
                  txe_ff[g] <= 1'b1;
                  ack_ff[g] <= 1'b1;
               end else if (tx_flag_wr &&
                            reg_wdata[`TXE_LSB+g]) begin
                  txe_ff[g] <= 1'b0;
                  ack_ff[g] <= 1'b0;
               end
               if (sent || grant) begin
                  creq_ff[g] <= 1'b0;
               end else if (reg_wr && (reg_addr == `OFS_TX_CTRL)) begin
                  creq_ff[g] <= reg_wdata[`CREQ_LSB+g] && !txe_ff[g];
               end
               if (en_ff && pe_arb_start) begin
                  busy_ff[g] <= pick_ok && (pick == g);
               end else if (pe_tx_done || pe_tx_err || pe_arb_lost ||
                            !en_ff) begin
                  busy_ff[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // Register read port with one cycle of latency.
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata_ff <= 8'h00;
      end else if (!reg_rd) begin
         reg_rdata_ff <= 8'h00;
      end else if (rslot[6]) begin
         if (rslot[3:0] == `RANK_IDX) begin
            reg_rdata_ff <= rank_wide[7:0];
         end else begin
            reg_rdata_ff <= tx_mem[rmem_idx];
         end
      end else if ((reg_addr >= `OFS_RX_WIN) &&
                   (reg_addr < `OFS_RX_WIN + `BUF_BYTES)) begin
         reg_rdata_ff <= rx_fg[reg_addr[3:0]];
      end else begin
         case (reg_addr)
            `OFS_OPTION2: reg_rdata_ff <= {7'h00, en_ff};
            `OFS_MODE: reg_rdata_ff <= {7'h00, loopback_ff};
            `OFS_RX_FLAG: reg_rdata_ff <= {6'h00, ovr_ff, rxf_ff};
            `OFS_RX_IE: reg_rdata_ff <= {6'h00, ovrie_ff, rxfie_ff};
            `OFS_TX_FLAG: reg_rdata_ff <= {1'b0, ack_ff, 1'b0, txe_ff};
            `OFS_TX_CTRL: reg_rdata_ff <= {1'b0, txie_ff, 1'b0, creq_ff};
            default: reg_rdata_ff <= 8'h00;
         endcase
      end
   end

   // Pins, engine handshake and interrupt levels, all registered.
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         can_tx_ff <= 1'b1;
         can_rx_sync_ff <= 1'b1;
         tx_byte_ff <= 8'h00;
         ack_en_ff <= 1'b0;
         module_en_ff <= 1'b0;
         rx_irq_ff <= 1'b0;
         err_irq_ff <= 1'b0;
         tx_irq_ff <= 1'b0;
      end else begin
         can_tx_ff <= en_ff ? pe_tx_bit : 1'b1;
         can_rx_sync_ff <= rx_sync_ff;
         tx_byte_ff <= (pe_tx_idx < `BUF_BYTES) ? tx_mem[tmem_idx] : 8'h00;
         ack_en_ff <= en_ff && (!own_ff || loopback_ff);
         module_en_ff <= en_ff;
         rx_irq_ff <= nxt_rxf && rxfie_ff;
         err_irq_ff <= nxt_ovr && ovrie_ff;
         tx_irq_ff <= |(txe_ff & txie_ff);
      end
   end

endmodule // can_message_buffering

//--- tb/can_buf_props.sv
`timescale 1ns/1ps
module can_buf_props #(
   parameter RANK_W = 8
) (
   input wire ref_clk,
   input wire rst_b,
   input wire reg_wr,
   input wire can_rx,
   input wire can_tx_ff,
   input wire can_rx_sync_ff,
   input wire pe_tx_bit,
   input wire pe_rx_ok,
   input wire pe_arb_start,
   input wire pe_arb_lost,
   input wire pe_tx_done,
   input wire pe_tx_err,
   input wire tx_req_ff,
   input wire [1:0] tx_sel_ff,
   input wire module_en_ff,
   input wire rx_irq_ff,
   input wire tx_irq_ff
);
   // All checks run on the module clock and rest during reset.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   a_tx_off_recessive: assert property (
      !module_en_ff && !$past(module_en_ff) |-> can_tx_ff)
      else $error("tx pin not recessive while off");
   a_tx_pin_level: assert property (
      module_en_ff && $past(module_en_ff) |-> can_tx_ff == $past(pe_tx_bit))
      else $error("tx pin level");
   a_rx_sync_depth: assert property (
      can_rx_sync_ff == $past(can_rx, 3)) else $error("rx sync depth");
   a_req_from_arb: assert property (
      $rose(tx_req_ff) |-> $past(pe_arb_start))
      else $error("tx request without arbitration");
   a_req_ends: assert property (
      tx_req_ff && !pe_arb_start && (pe_tx_done || pe_tx_err || pe_arb_lost)
      |=> !tx_req_ff) else $error("tx request held after end");
   a_sel_held: assert property (
      tx_req_ff && $past(tx_req_ff) && !$past(pe_arb_start)
      |-> $stable(tx_sel_ff)) else $error("selection moved mid frame");
   a_rx_irq_cause: assert property (
      $rose(rx_irq_ff) |-> $past(pe_rx_ok) || $past(reg_wr)
      || $past(reg_wr, 2)) else $error("rx irq without frame");
   a_tx_irq_cause: assert property (
      $rose(tx_irq_ff) |-> $past(pe_tx_done, 2) || $past(pe_arb_lost, 2)
      || $past(pe_arb_lost, 3) || $past(pe_tx_err, 3) || $past(reg_wr)
      || $past(reg_wr, 2) || $past(reg_wr, 3) || $past(reg_wr, 4))
      else $error("tx irq without cause");
   // Main scenarios.
   c_tx_req: cover property ($rose(tx_req_ff));
   c_rx_irq: cover property ($rose(rx_irq_ff));
   c_tx_irq: cover property ($rose(tx_irq_ff));
endmodule // can_buf_props
bind can_message_buffering can_buf_props #(.RANK_W(RANK_W)) can_buf_props_inst (
   .ref_clk, .rst_b, .reg_wr, .can_rx, .can_tx_ff, .can_rx_sync_ff,
   .pe_tx_bit, .pe_rx_ok, .pe_arb_start, .pe_arb_lost, .pe_tx_done,
   .pe_tx_err, .tx_req_ff, .tx_sel_ff, .module_en_ff, .rx_irq_ff, .tx_irq_ff
);

//--- tb/can_bus_model.sv
`timescale 1ns/1ps
module can_bus_model (
   input wire ref_clk,
   input wire can_tx_ff,
   input wire remote_dom,
   output wire can_rx,
   output reg arb_lost = 1'h0
);
   // Wired-AND bus: any dominant 0 wins over a recessive 1.
   assign can_rx = can_tx_ff & ~remote_dom;
   // Sending recessive while the bus reads dominant loses arbitration.
   always @(posedge ref_clk) begin
      arb_lost <= can_tx_ff & ~can_rx;
   end
endmodule // can_bus_model

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic ref_clk = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
   logic pe_tx_bit = 1'h1, pe_rx_wr = 1'h0, pe_rx_ok = 1'h0, remote_dom = 1'h0;
   logic pe_rx_hit = 1'h0, pe_arb_start = 1'h0, pe_tx_done = 1'h0;
   logic pe_tx_err = 1'h0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, pe_rx_byte = 8'h00;
   logic [3:0] pe_rx_idx = 4'h0, pe_tx_idx = 4'h0;
   wire [7:0] reg_rdata_ff, tx_byte_ff;
   wire [1:0] tx_sel_ff;
   wire can_rx, can_tx_ff, can_rx_sync_ff, pe_arb_lost, tx_req_ff, ack_en_ff;
   wire module_en_ff, rx_irq_ff, err_irq_ff, tx_irq_ff;
   int fail_count = 0, comparisons = 0, cyc = 0;
   can_message_buffering #(.RANK_W(8)) can_message_buffering_inst (
      .ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata_ff, .can_rx, .can_tx_ff, .can_rx_sync_ff, .pe_tx_bit,
      .pe_rx_wr, .pe_rx_idx, .pe_rx_byte, .pe_rx_ok, .pe_rx_hit,
      .pe_arb_start, .pe_arb_lost, .pe_tx_done, .pe_tx_err, .pe_tx_idx,
      .tx_byte_ff, .tx_req_ff, .tx_sel_ff, .ack_en_ff, .module_en_ff,
      .rx_irq_ff, .err_irq_ff, .tx_irq_ff
   );
   can_bus_model can_bus_model_inst (.ref_clk, .can_tx_ff, .remote_dom,
      .can_rx, .arb_lost(pe_arb_lost));
   // Clock and a cycle ceiling that cuts a hang short.
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         end_of_test();
      end
   end
   task end_of_test;
      $display("fails %0d comparisons %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input string n, input [7:0] e, input [7:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   // One-cycle write strobe.
   task wr(input [7:0] a, input [7:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'h1;
      @(posedge ref_clk);
      reg_wr <= 1'h0;
   endtask
   // Read data stands only in the cycle after the strobe.
   task rc(input [7:0] a, input [7:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      #1;
      chk("reg", e, reg_rdata_ff);
   endtask
   // Engine pulses: rx_ok, hit, arb_start, tx_done, tx_err.
   task ev(input [4:0] v);
      @(posedge ref_clk);
      {pe_rx_ok, pe_rx_hit, pe_arb_start, pe_tx_done, pe_tx_err} <= v;
      @(posedge ref_clk);
      {pe_rx_ok, pe_rx_hit, pe_arb_start, pe_tx_done, pe_tx_err} <= 5'h00;
      #1;
   endtask
   // A whole 13-byte frame, then end of frame with the filter result.
   task rx(input [7:0] b, input h);
      for (int i = 0; i < 13; i++) begin
         @(posedge ref_clk);
         pe_rx_wr <= 1'h1;
         pe_rx_idx <= i[3:0];
         pe_rx_byte <= b + i[7:0];
      end
      @(posedge ref_clk);
      pe_rx_wr <= 1'h0;
      ev({1'h1, h, 3'h0});
   endtask
   initial begin
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'h1;
      rc(8'h04, 8'h07);
      rc(8'h02, 8'h00);
      chk("can_tx", 8'h01, {7'h00, can_tx_ff});
      rx(8'h10, 1'h1);
      rc(8'h02, 8'h00);
      $display("test reset done");
      wr(8'h00, 8'h01);
      pe_tx_bit <= 1'h0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk("can_tx", 8'h00, {7'h00, can_tx_ff});
      pe_tx_bit <= 1'h1;
      wr(8'h03, 8'h03);
      rx(8'h20, 1'h1);
      @(posedge ref_clk);
      #1;
      chk("rx_irq", 8'h01, {7'h00, rx_irq_ff});
      rc(8'h02, 8'h01);
      rc(8'h40, 8'h20);
      rc(8'h4C, 8'h2C);
      rx(8'h30, 1'h0);
      rx(8'h40, 1'h1);
      rc(8'h40, 8'h20);
      rx(8'h50, 1'h1);
      rc(8'h02, 8'h03);
      chk("err_irq", 8'h01, {7'h00, err_irq_ff});
      wr(8'h02, 8'h01);
      rc(8'h02, 8'h03);
      rc(8'h4C, 8'h4C);
      wr(8'h02, 8'h03);
      rc(8'h02, 8'h00);
      $display("test receive done");
      wr(8'h5D, 8'h05);
      wr(8'h6D, 8'h02);
      wr(8'h7D, 8'h09);
      wr(8'h5B, 8'hB0);
      wr(8'h60, 8'hA1);
      rc(8'h5B, 8'hB0);
      wr(8'h05, 8'h70);
      wr(8'h04, 8'h07);
      rc(8'h04, 8'h00);
      ev(5'h04);
      chk("tx_sel", 8'h01, {6'h00, tx_sel_ff});
      repeat (2) @(posedge ref_clk);
      #1;
      chk("ack_en", 8'h00, {7'h00, ack_en_ff});
      chk("tx_byte", 8'hA1, tx_byte_ff);
      rx(8'h60, 1'h1);
      rc(8'h02, 8'h00);
      ev(5'h01);
      wr(8'h7D, 8'h00);
      ev(5'h04);
      chk("tx_sel", 8'h02, {6'h00, tx_sel_ff});
      ev(5'h02);
      rc(8'h04, 8'h04);
      chk("tx_irq", 8'h01, {7'h00, tx_irq_ff});
      $display("test transmit done");
      // Cancel an idle buffer and the one on the bus, then lose the bus.
      ev(5'h04);
      wr(8'h05, 8'h73);
      rc(8'h04, 8'h15);
      remote_dom <= 1'h1;
      repeat (2) @(posedge ref_clk);
      remote_dom <= 1'h0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk("tx_req", 8'h00, {7'h00, tx_req_ff});
      rc(8'h04, 8'h37);
      $display("test cancel done");
      wr(8'h01, 8'h01);
      wr(8'h04, 8'h01);
      ev(5'h04);
      chk("tx_sel", 8'h00, {6'h00, tx_sel_ff});
      rx(8'h70, 1'h1);
      rc(8'h02, 8'h01);
      rc(8'h40, 8'h70);
      $display("test loopback done");
      end_of_test();
   end
endmodule // testbench
